//--- design/melody_buzzer_map.svh
// Register addresses, field positions, reset values and timing counts
`ifndef MELODY_BUZZER_MAP_SVH
`define MELODY_BUZZER_MAP_SVH

`define MB_TEMPO_ADDR   12'h096
`define MB_CTRL_ADDR    12'h097
`define MB_FLAG_BIT     3
`define MB_BUZEN_BIT    2
`define MB_END_BIT      15
`define MB_TEMPO_RST    4'h0
`define MB_CTRL_RST     4'h0
`define MB_TEMPO_STEP   17'h01000
`define MB_SINGLE_FALLS 2'h2

`endif

//--- design/melody_buzzer_pkg.sv
// Types shared by the melody and buzzer driver
package melody_buzzer_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_PLAY
   } fsm_t;

   typedef enum logic [1:0] {
      BUZ_INTER1,
      BUZ_INTER2,
      BUZ_SINGLE,
      BUZ_CONT
   } buz_mode_t;

   // Register port request from the CPU core
   typedef struct packed {
      logic        we;
      logic        re;
      logic [11:0] addr;
      logic [3:0]  wdata;
   } sfr_req_t;

   // Time base levels and the double-rate low-speed tick
   typedef struct packed {
      logic tick2x;
      logic tb_4khz;
      logic tb_32hz;
      logic tb_8hz;
      logic tb_1hz;
   } timebase_t;

   typedef struct packed {
      fsm_t        fsm;
      logic [3:0]  tempo;
      logic        melody_active_flag;
      logic        buzzer_enable;
      buz_mode_t   mode;
      logic [15:0] addr;
      logic [15:0] pend_addr;
      logic        pend;
      logic        end_bit;
      logic [5:0]  dur;
      logic [6:0]  pitch;
      logic [5:0]  dur_cnt;
      logic [16:0] tempo_cnt;
      logic [7:0]  tone_cnt;
      logic [1:0]  fall_cnt;
      logic        tb32_prev;
      logic        pin;
      logic        irq;
      logic        rom_req;
      logic [3:0]  rdata;
   } state_t;

endpackage : melody_buzzer_pkg

//--- design/melody_buzzer_driver.sv
// Melody sequencer and buzzer driver sharing one tone output pin
`timescale 1ns/1ps
`include "melody_buzzer_map.svh"

module melody_buzzer_driver #(
   parameter logic [16:0] TEMPO_STEP = `MB_TEMPO_STEP // ticks per code step
) (
   input  wire logic                         core_clk,  // 50 MHz clock
   input  wire logic                         rst,       // Sync reset
   input  wire melody_buzzer_pkg::sfr_req_t  sfr_req,   // Register access
   output      logic [3:0]                   sfr_rdata, // Read data
   input  wire logic                         melody_start_instruction, // Start
   input  wire logic [15:0]                  msa_addr,  // Start address
   output      logic                         rom_req,   // Fetch request
   output      logic [15:0]                  rom_addr,  // Fetch address
   input  wire logic                         rom_valid, // Fetch answer
   input  wire logic [15:0]                  rom_data,  // Fetched word
   input  wire melody_buzzer_pkg::timebase_t tb,        // Time base levels
   output      logic                         tone_output_pin, // Speaker
   output      logic                         melody_irq // End request pulse
);
   import melody_buzzer_pkg::*;

   state_t      q;
   state_t      d;
   logic [16:0] tempo_lim;
   logic [3:0]  tempo_sel;
   logic [5:0]  dur_eff;
   logic [7:0]  tone_last;
   logic        audible;
   logic        tone_lvl;
   logic        buz_gate;
   logic        buz_out;
   logic        fall32;
   logic        note_done;
   logic        ctrl_wr;

   // Tempo period: codes 0 and 1 share the fastest rate
   always_comb
   begin
      tempo_sel = (q.tempo == 4'h0) ? 4'h1 : q.tempo;
      tempo_lim = 17'(TEMPO_STEP * ({13'h0000, tempo_sel} + 17'h00001));
   end

   // Note decode and tone waveform
   always_comb
   begin
      dur_eff   = (q.dur == 6'h00) ? 6'h01 : q.dur;
      tone_last = {1'b0, q.pitch} + 8'h01;
      audible   = (q.pitch[6:2] != 5'h00);
      tone_lvl  = (q.tone_cnt < ((tone_last + 8'h01) >> 1));
   end

   // Buzzer gating by time base; mode order is an assumption
   always_comb
   begin
      case (q.mode)
         BUZ_INTER1: buz_gate = tb.tb_8hz;
         BUZ_INTER2: buz_gate = tb.tb_8hz & ~tb.tb_1hz;
         BUZ_SINGLE: buz_gate = 1'b1;
         BUZ_CONT:   buz_gate = 1'b1;
         default:    buz_gate = 1'b0;
      endcase
      buz_out = q.buzzer_enable & buz_gate & tb.tb_4khz;
      fall32  = q.tb32_prev & ~tb.tb_32hz;
      ctrl_wr = sfr_req.we && (sfr_req.addr == `MB_CTRL_ADDR);
   end

   // Note length ends on the last tempo unit of the last duration step
   assign note_done = (q.fsm == ST_PLAY) && tb.tick2x &&
                      (q.tempo_cnt == tempo_lim - 17'h00001) &&
                      (q.dur_cnt + 6'h01 >= dur_eff);

   // Next-state logic
   always_comb
   begin
      d         = q;
      d.irq     = 1'b0;
      d.tb32_prev = tb.tb_32hz;

      // Register writes
      if (sfr_req.we && (sfr_req.addr == `MB_TEMPO_ADDR))
      begin
         d.tempo = sfr_req.wdata;
      end
      if (ctrl_wr)
      begin
         d.buzzer_enable = sfr_req.wdata[`MB_BUZEN_BIT];
         d.mode          = buz_mode_t'(sfr_req.wdata[1:0]);
         d.fall_cnt      = 2'h0;
      end

      // Single tone: second falling 32 Hz edge ends it
      if (!ctrl_wr && q.buzzer_enable && q.mode == BUZ_SINGLE && fall32)
      begin
         if (q.fall_cnt + 2'h1 == `MB_SINGLE_FALLS)
         begin
            d.buzzer_enable = 1'b0;
            d.fall_cnt      = 2'h0;
         end
         else
         begin
            d.fall_cnt = q.fall_cnt + 2'h1;
         end
      end

      // Sequencer
      case (q.fsm)
         ST_IDLE:
         begin
            d.tone_cnt = 8'h00;
         end
         ST_FETCH:
         begin
            if (rom_valid)
            begin
               d.end_bit   = rom_data[`MB_END_BIT];
               d.dur       = rom_data[13:8];
               d.pitch     = rom_data[6:0];
               d.addr      = q.addr + 16'h0001;
               d.irq       = rom_data[`MB_END_BIT];
               d.dur_cnt   = 6'h00;
               d.tempo_cnt = 17'h00000;
               d.fsm       = ST_PLAY;
            end
         end
         ST_PLAY:
         begin
            if (tb.tick2x)
            begin
               d.tone_cnt = (q.tone_cnt >= tone_last) ? 8'h00
                                                      : q.tone_cnt + 8'h01;
               if (q.tempo_cnt == tempo_lim - 17'h00001)
               begin
                  d.tempo_cnt = 17'h00000;
                  d.dur_cnt   = q.dur_cnt + 6'h01;
               end
               else
               begin
                  d.tempo_cnt = q.tempo_cnt + 17'h00001;
               end
            end
            if (note_done)
            begin
               if (!q.end_bit)
               begin
                  d.fsm = ST_FETCH;
               end
               else if (q.pend)
               begin
                  d.addr = q.pend_addr;
                  d.pend = 1'b0;
                  d.fsm  = ST_FETCH;
               end
               else
               begin
                  d.fsm = ST_IDLE;
                  d.melody_active_flag = 1'b0;
               end
            end
         end
         default:
         begin
            d.fsm = ST_IDLE;
         end
      endcase

      // Abort after the sequencer so a fetch or note end cannot undo it;
      // only a clear acts, software cannot start by writing one
      if (ctrl_wr && !sfr_req.wdata[`MB_FLAG_BIT] && q.melody_active_flag)
      begin
         d.melody_active_flag = 1'b0;
         d.fsm                = ST_IDLE;
         d.pend               = 1'b0;
      end

      // Start wins over a same-cycle abort
      if (melody_start_instruction)
      begin
         d.melody_active_flag = 1'b1;
         d.buzzer_enable      = 1'b0;
         d.fall_cnt           = 2'h0;
         if (d.fsm == ST_IDLE)
         begin
            d.addr     = msa_addr;
            d.pend     = 1'b0;
            d.fsm      = ST_FETCH;
            d.tone_cnt = 8'h00;
         end
         else
         begin
            d.pend_addr = msa_addr;
            d.pend      = 1'b1;
         end
      end

      d.rom_req = (d.fsm == ST_FETCH);

      // Melody owns the pin whenever active
      if (q.melody_active_flag)
      begin
         d.pin = (q.fsm == ST_PLAY) && audible && tone_lvl;
      end
      else
      begin
         d.pin = buz_out;
      end

      // Registered read data
      if (sfr_req.re && sfr_req.addr == `MB_TEMPO_ADDR)
      begin
         d.rdata = q.tempo;
      end
      else if (sfr_req.re && sfr_req.addr == `MB_CTRL_ADDR)
      begin
         d.rdata = {q.melody_active_flag, q.buzzer_enable, q.mode};
      end
      else
      begin
         d.rdata = 4'h0;
      end
   end

   // State register
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         q                    <= '0;
         q.fsm                <= ST_IDLE;
         q.tempo              <= `MB_TEMPO_RST;
         q.melody_active_flag <= 1'b0;
         q.buzzer_enable      <= 1'b0;
         q.mode               <= BUZ_INTER1;
      end
      else
      begin
         q <= d;
      end
   end

   assign sfr_rdata       = q.rdata;
   assign rom_req         = q.rom_req;
   assign rom_addr        = q.addr;
   assign tone_output_pin = q.pin;
   assign melody_irq      = q.irq;

   AST_RESET_IDLE: assert property (@(posedge core_clk)
      rst |=> !q.melody_active_flag && q.fsm == ST_IDLE && !q.buzzer_enable)
      else $error("reset left the generator active");

   AST_START_SETS_FLAG: assert property (@(posedge core_clk)
      disable iff (rst) melody_start_instruction |=> q.melody_active_flag)
      else $error("start did not set the active flag");

   AST_START_KILLS_BUZZER: assert property (@(posedge core_clk)
      disable iff (rst)
      melody_start_instruction && q.buzzer_enable |=> !q.buzzer_enable)
      else $error("buzzer kept sounding after start");

   AST_ABORT: assert property (@(posedge core_clk)
      disable iff (rst)
      ctrl_wr && !sfr_req.wdata[`MB_FLAG_BIT] && !melody_start_instruction
      |=> q.fsm == ST_IDLE && !q.melody_active_flag && !rom_req)
      else $error("abort did not stop the generator");

   AST_TEMPO_WRITE: assert property (@(posedge core_clk)
      disable iff (rst)
      sfr_req.we && sfr_req.addr == `MB_TEMPO_ADDR
      |=> q.tempo == $past(sfr_req.wdata))
      else $error("tempo write not stored");

   AST_END_IRQ: assert property (@(posedge core_clk)
      disable iff (rst)
      q.fsm == ST_FETCH && rom_valid && rom_data[`MB_END_BIT]
      |=> melody_irq ##1 !melody_irq)
      else $error("end word did not raise one irq pulse");

   AST_QUIET_PIN: assert property (@(posedge core_clk)
      disable iff (rst)
      !q.melody_active_flag && !q.buzzer_enable |=> !tone_output_pin)
      else $error("pin driven while idle");

   AST_MELODY_PRIORITY: assert property (@(posedge core_clk)
      disable iff (rst)
      q.melody_active_flag && q.fsm != ST_PLAY |=> !tone_output_pin)
      else $error("buzzer reached pin during melody");

   AST_SINGLE_END: assert property (@(posedge core_clk)
      disable iff (rst)
      q.mode == BUZ_SINGLE && q.buzzer_enable && fall32 && !ctrl_wr &&
      q.fall_cnt == 2'h1 |=> !q.buzzer_enable)
      else $error("single tone outlived second fall");

   AST_STOP_AFTER_END: assert property (@(posedge core_clk)
      disable iff (rst)
      note_done && q.end_bit && !q.pend && !melody_start_instruction &&
      !ctrl_wr |=> q.fsm == ST_IDLE && !q.melody_active_flag)
      else $error("playback continued after end word");

endmodule : melody_buzzer_driver

//--- verif/melody_rom_model.sv
// Program memory model serving the melody fetch path
`timescale 1ns/1ps

module melody_rom_model (
   input  wire logic        core_clk,  // System clock
   input  wire logic        rst,       // Sync reset
   input  wire logic        slow,      // Stretch answer latency
   input  wire logic        rom_req,   // Fetch request
   input  wire logic [15:0] rom_addr,  // Word address
   output      logic        rom_valid, // Answer pulse
   output      logic [15:0] rom_data   // Word, scrambled when idle
);
   // Slots 2 and 3 hold the two silent end words used before an abort
   logic [15:0] mem [16] = '{16'h0805, 16'h8004, 16'h8000, 16'h8000,
      16'h0800, 16'h8000, 16'h4085, 16'h0105, 16'h8000, 16'h8105,
      16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000};
   logic [15:0] last_q;
   logic [2:0]  wait_q;

   // One answer per request, after a short or a long wait
   always_ff @(posedge core_clk)
   begin
      rom_valid <= 1'b0;
      wait_q    <= 3'h0;
      if (rst)
         last_q <= 16'h0;
      else if (rom_req && !rom_valid)
      begin
         if (wait_q >= (slow ? 3'h5 : 3'h1))
         begin
            rom_valid <= 1'b1;
            last_q    <= mem[rom_addr[3:0]];
         end
         else
            wait_q <= wait_q + 3'h1;
      end
   end

   // Idle bus shows the inverse, so a stale word is never mistaken
   assign rom_data = rom_valid ? last_q : ~last_q;
endmodule : melody_rom_model

//--- verif/tb.sv
// Self-checking bench for the melody and buzzer driver
`timescale 1ns/1ps
`include "melody_buzzer_map.svh"

module tb;
   import melody_buzzer_pkg::*;
   logic        core_clk, rst, start, rom_req, rom_valid, pin, irq, slow;
   logic        req_q;
   logic [15:0] msa_addr, rom_addr, rom_data, rv;
   logic [3:0]  sfr_rdata;
   sfr_req_t    sfr_req;
   timebase_t   tbase;
   int          err_total, checks, cyc;
   int          rise_cyc[$];
   logic [15:0] rise_adr[$];

   melody_buzzer_driver #(.TEMPO_STEP(17'h2)) melody_buzzer_driver_i (
      .core_clk, .rst, .sfr_req, .sfr_rdata,
      .melody_start_instruction(start), .msa_addr, .rom_req, .rom_addr,
      .rom_valid, .rom_data, .tb(tbase), .tone_output_pin(pin),
      .melody_irq(irq));

   melody_rom_model melody_rom_model_i (.core_clk, .rst, .slow, .rom_req,
      .rom_addr, .rom_valid, .rom_data);

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Tick every other cycle; fetch log and hang guard
   always @(negedge core_clk) tbase.tick2x <= ~tbase.tick2x;
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      req_q <= rom_req;
      if (rom_req && !req_q)
      begin
         rise_cyc.push_back(cyc);
         rise_adr.push_back(rom_addr);
      end
      if (cyc > 5000)
      begin
         err_total++;
         test_done();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc_n

   task automatic wr(input logic [11:0] a, input logic [3:0] d);
      sfr_req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(negedge core_clk);
      sfr_req.we = 1'b0;
      // Idle cycle so a following request never re-raises we at once
      @(negedge core_clk);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      sfr_req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 4'h0};
      @(negedge core_clk);
      // Read data stands only in the cycle after re
      d = {12'h0, sfr_rdata};
      sfr_req.re = 1'b0;
      @(negedge core_clk);
   endtask : rd

   task automatic strt(input logic [15:0] a);
      start = 1'b1;
      msa_addr = a;
      @(negedge core_clk);
      start = 1'b0;
      rise_cyc.delete();
      rise_adr.delete();
   endtask : strt

   task automatic wait_idle();
      rv = 16'h8;
      for (int i = 0; i < 100 && rv[3]; i++) rd(`MB_CTRL_ADDR, rv);
      check(rv & 16'h8, 16'h0);
   endtask : wait_idle

   task automatic wait_irq();
      for (int i = 0; i < 300 && !irq; i++) @(negedge core_clk);
      check(16'(irq), 16'h1);
   endtask : wait_irq

   task automatic t_regs();
      rd(`MB_TEMPO_ADDR, rv);
      check(rv, 16'h0);
      rd(`MB_CTRL_ADDR, rv);
      check(rv, 16'h0);
      wr(`MB_TEMPO_ADDR, 4'hf);
      wr(12'h098, 4'h3);
      rd(`MB_TEMPO_ADDR, rv);
      check(rv, 16'hf);
      rd(12'h098, rv);
      check(rv, 16'h0);
      // Setting the flag by software must not start anything
      wr(`MB_CTRL_ADDR, 4'h8);
      rd(`MB_CTRL_ADDR, rv);
      check(rv | 16'(rom_req), 16'h0);
   endtask : t_regs

   task automatic t_buzz();
      logic e;
      for (int m = 0; m < 4; m++)
         for (int g = 0; g < 8; g++)
         begin
            tbase.tb_8hz = g[0];
            tbase.tb_1hz = g[1];
            tbase.tb_4khz = g[2];
            wr(`MB_CTRL_ADDR, 4'(4 + m));
            cyc_n(3);
            e = g[2] & ((m == 0) ? g[0] : (m == 1) ? g[0] & ~g[1] : 1'b1);
            check(16'(pin), 16'(e));
         end
      wr(`MB_CTRL_ADDR, 4'h3);
      cyc_n(3);
      check(16'(pin), 16'h0);
   endtask : t_buzz

   task automatic t_single();
      tbase = '{tick2x: tbase.tick2x, default: 1'b1};
      wr(`MB_CTRL_ADDR, 4'h6);
      tbase.tb_32hz = 1'b0;
      cyc_n(3);
      rd(`MB_CTRL_ADDR, rv);
      check({rv[11:0], 3'h0, pin}, 16'h61);
      tbase.tb_32hz = 1'b1;
      cyc_n(3);
      tbase.tb_32hz = 1'b0;
      cyc_n(3);
      rd(`MB_CTRL_ADDR, rv);
      check({rv[11:0], 3'h0, pin}, 16'h20);
   endtask : t_single

   task automatic t_melody();
      int t0, per, n;
      logic pp;
      t0 = 0;
      per = 0;
      n = 0;
      pp = 1'b1;
      wr(`MB_TEMPO_ADDR, 4'h0);
      wr(`MB_CTRL_ADDR, 4'h7);
      strt(16'h0);
      rd(`MB_CTRL_ADDR, rv);
      check(rv, 16'hb);
      // Second period inside the long first note
      for (int i = 0; i < 50; i++)
      begin
         @(negedge core_clk);
         // Skip the first period, which starts off the tick phase
         if (pin && !pp && n == 2) per = cyc - t0;
         if (pin && !pp) t0 = cyc;
         if (pin && !pp) n++;
         pp = pin;
      end
      check(16'(per), 16'h0e);
      wait_irq();
      wait_idle();
      check({rise_adr[0][7:0], rise_adr[1][7:0]}, 16'h0001);
      check(16'(rise_cyc.size()), 16'h2);
   endtask : t_melody

   task automatic t_abort();
      strt(16'h0);
      cyc_n(10);
      // Abort: start at the end words queued first, then the flag cleared
      strt(16'h2);
      wr(`MB_CTRL_ADDR, 4'h0);
      cyc_n(80);
      rd(`MB_CTRL_ADDR, rv);
      check({rv[11:0], 3'h0, pin}, 16'h0);
      check(16'(rise_cyc.size()), 16'h0);
      strt(16'h6);
      cyc_n(10);
      check(rise_adr[0], 16'h6);
      wait_idle();
   endtask : t_abort

   task automatic t_seam();
      int hi;
      hi = 0;
      wr(`MB_CTRL_ADDR, 4'h3);
      strt(16'h4);
      wr(`MB_CTRL_ADDR, 4'hf);
      for (int i = 0; i < 40; i++)
      begin
         @(negedge core_clk);
         hi += pin;
      end
      check(16'(hi), 16'h0);
      wait_irq();
      strt(16'h9);
      wait_idle();
      check(rise_adr[0], 16'h9);
      check(16'(rise_cyc.size()), 16'h1);
      wr(`MB_CTRL_ADDR, 4'h0);
   endtask : t_seam

   task automatic t_tempo();
      int len[3];
      int code[3] = '{0, 1, 3};
      int d0;
      for (int k = 0; k < 3; k++)
      begin
         wr(`MB_TEMPO_ADDR, 4'(code[k]));
         strt(16'h6);
         wait_idle();
         d0 = rise_cyc[1] - rise_cyc[0];
         len[k] = rise_cyc[2] - rise_cyc[1];
         // First note may gain one cycle from the tick phase
         check(16'(d0 - len[k]) & 16'hfffe, 16'h0);
      end
      check(16'(len[1]), 16'(len[0]));
      check(16'(len[2] - len[0]), 16'h8);
   endtask : t_tempo

   task automatic test_done();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   initial
   begin
      {rst, start, slow, req_q} = 4'b1000;
      msa_addr = 16'h0;
      sfr_req = '0;
      tbase = '0;
      err_total = 0;
      checks = 0;
      cyc = 0;
      cyc_n(2);
      rst = 1'b0;
      t_regs();
      t_buzz();
      t_single();
      t_melody();
      t_abort();
      t_seam();
      slow = 1'b1;
      t_tempo();
      test_done();
   end
endmodule : tb
